// ===== src/dag_regs.svh
// Register offsets, field positions, reset values for the data address generator.
// Assumes inclusion by bare name from the top module.
`ifndef DAG_REGS_SVH
`define DAG_REGS_SVH

// Byte offsets on the APB register window
`define DAG_OFF_STAT_ZERO 12'h000
`define DAG_OFF_STAT_ONE 12'h004
`define DAG_OFF_LAST 12'h008
`define DAG_OFF_PTR0 12'h020
`define DAG_OFF_PTR_END 12'h03C

// Field positions inside the status words and the last-access word
`define DAG_PAGE_LSB 0
`define DAG_PAGE_MSB 8
`define DAG_SEL_LSB 13
`define DAG_SEL_MSB 15
`define DAG_MAP_BIT 12
`define DAG_LAST_WR_BIT 16
`define DAG_LAST_CMP_BIT 17

// Reset values
`define DAG_RST_PTR 16'h0000
`define DAG_RST_PAGE 9'h000
`define DAG_RST_SEL 3'h0
`define DAG_RST_MAP 1'b0

// Unit step for plain increment and decrement
`define DAG_STEP_ONE 16'h0001

`endif

// ===== src/dag_pkg.sv
// Types shared by the data address generator and its pointer math unit.
// Assumes dag_regs.svh holds the numeric constants.
package dag_pkg;
    // Pointer math operations requested by the decoder
    typedef enum logic [2:0] {
        DAG_OP_NONE = 3'h0,
        DAG_OP_INC = 3'h1,
        DAG_OP_DEC = 3'h2,
        DAG_OP_BR_INC = 3'h3,
        DAG_OP_BR_DEC = 3'h4,
        DAG_OP_CMP_EQ = 3'h5,
        DAG_OP_CMP_LT = 3'h6,
        DAG_OP_CMP_GT = 3'h7
    } dag_op_t;

    typedef logic [15:0] dag_word_t;
    typedef logic [2:0] dag_sel_t;
    typedef logic [8:0] dag_page_t;
endpackage

// ===== src/dag_math_if.sv
// Carrier between the address generator and its pointer math unit.
// Assumes both ends run in the same pclk domain; the unit is combinational.
`timescale 1ns/1ps
`default_nettype none
interface dag_math_if;
    import dag_pkg::*;
    dag_word_t a;
    dag_word_t b;
    dag_op_t op;
    dag_word_t res;
    logic eq;
    logic lt;

    modport unit (input a, input b, input op, output res, output eq, output lt);
    modport user (output a, output b, output op, input res, input eq, input lt);
endinterface
`default_nettype wire

// ===== src/dag_math_unit.sv
// Pointer math unit: add, subtract, bit-reversed add and subtract, compare.
// Assumes the caller registers the result; this module is purely combinational.
`timescale 1ns/1ps
`default_nettype none
module dag_math_unit
(
    // Operands and result
    dag_math_if.unit m
);
    import dag_pkg::*;

    // Mirror a word so that carries run from the top bit downward
    function automatic dag_word_t rev16(input dag_word_t w);
        dag_word_t r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = w[15 - i];
        end
        return r;
    endfunction

    // Result and compare flags; wrap is silent, no carry flag exists
    always_comb
    begin
        m.res = m.a;
        m.eq = (m.a == m.b);
        m.lt = (m.a < m.b);
        case (m.op)
            DAG_OP_INC: m.res = m.a + m.b;
            DAG_OP_DEC: m.res = m.a - m.b;
            DAG_OP_BR_INC: m.res = rev16(rev16(m.a) + rev16(m.b));
            DAG_OP_BR_DEC: m.res = rev16(rev16(m.a) - rev16(m.b));
            default: m.res = m.a;
        endcase
    end
endmodule
`default_nettype wire

// ===== src/dag_top.sv
// Data address generator: eight pointers, page pointer, selector pair, address buses.
// Assumes a decoder issuing at most one access per cycle and an APB master.
// Operation
// - Eight 16-bit pointer registers, numbered zero to seven, hold data addresses.
// - Three-bit selector in status word zero picks the current pointer.
// - Three-bit copy in status word one keeps the selector's previous value.
// - Pointer math unit increments, decrements or compares pointer contents.
// - Direct address is page pointer on top, seven instruction bits below.
// - Nine-bit page pointer in status word zero picks one of 512 pages.
// - Each page is 128 contiguous words, page zero starting at zero.
// - Bit-reversed indirect mode runs carries from top bit toward bottom bit.
// - At most one data address is produced per cycle.
// - Bit 12 of status word one maps RAM block zero to program or data.
// - Read addresses and write addresses leave on separate 16-bit buses.
// - Indirect access uses the current pointer's contents as the address.
// - A selector change takes effect for accesses after the changing instruction.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dag_regs.svh"
module dag_top
#(
    parameter int NUM_PTR = 8,
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder request
    input wire logic instr_valid,
    input wire logic instr_indirect,
    input wire logic instr_write,
    input wire logic [6:0] instr_offset,
    input wire dag_pkg::dag_op_t instr_op,
    input wire logic instr_sel_load,
    input wire dag_pkg::dag_sel_t instr_sel_value,
    input wire logic instr_page_load,
    input wire dag_pkg::dag_page_t instr_page_value,
    // Memory address buses and status
    output dag_pkg::dag_word_t read_addr_bus,
    output logic read_valid,
    output dag_pkg::dag_word_t write_addr_bus,
    output logic write_valid,
    output logic cmp_true,
    output logic block_zero_map_flag,
    output dag_pkg::dag_sel_t current_pointer_select
);
    import dag_pkg::*;

    dag_word_t pointer_regs_q [NUM_PTR];
    dag_word_t pointer_regs_d [NUM_PTR];
    dag_sel_t sel_q;
    dag_sel_t sel_d;
    dag_sel_t prev_q;
    dag_sel_t prev_d;
    dag_page_t page_q;
    dag_page_t page_d;
    logic map_q;
    logic map_d;
    dag_word_t rd_addr_q;
    dag_word_t rd_addr_d;
    dag_word_t wr_addr_q;
    dag_word_t wr_addr_d;
    logic rd_vld_q;
    logic rd_vld_d;
    logic wr_vld_q;
    logic wr_vld_d;
    logic last_wr_q;
    logic last_wr_d;
    logic cmp_q;
    logic cmp_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    dag_word_t cur_ptr;
    dag_word_t access_addr;
    logic apb_setup;
    logic apb_wr;
    dag_math_if m ();

    // Register window decode, shared by read and write paths
    function automatic logic is_ptr(input logic [ADDR_W-1:0] a);
        return (a >= `DAG_OFF_PTR0) && (a <= `DAG_OFF_PTR_END) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return is_ptr(a) || (a == `DAG_OFF_STAT_ZERO) || (a == `DAG_OFF_STAT_ONE) || (a == `DAG_OFF_LAST);
    endfunction

    function automatic dag_sel_t ptr_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - `DAG_OFF_PTR0;
        return d[4:2];
    endfunction

    dag_math_unit u_math
    (
        .m(m)
    );

    // Current pointer and operand steering into the math unit
    always_comb
    begin
        cur_ptr = pointer_regs_q[sel_q];
        m.a = cur_ptr;
        m.op = instr_valid ? instr_op : DAG_OP_NONE;
        // Index step lives in pointer zero for bit-reversed and compare work
        case (m.op)
            DAG_OP_INC, DAG_OP_DEC: m.b = `DAG_STEP_ONE;
            default: m.b = pointer_regs_q[0];
        endcase
    end

    // Address formation for the single access of this cycle
    always_comb
    begin
        if (instr_indirect)
        begin
            access_addr = cur_ptr;
        end
        else
        begin
            access_addr = {page_q, instr_offset};
        end
    end

    // APB phase decode; writes land only on the completing access edge
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready_q && pwrite;

    // Next state of the architectural registers
    always_comb
    begin
        pointer_regs_d = pointer_regs_q;
        sel_d = sel_q;
        prev_d = prev_q;
        page_d = page_q;
        map_d = map_q;
        // Software writes first, so a same-cycle decoder update overrides them
        if (apb_wr && is_ptr(paddr))
        begin
            pointer_regs_d[ptr_idx(paddr)] = pwdata[15:0];
        end
        if (apb_wr && (paddr == `DAG_OFF_STAT_ONE))
        begin
            prev_d = pwdata[`DAG_SEL_MSB:`DAG_SEL_LSB];
            map_d = pwdata[`DAG_MAP_BIT];
        end
        if (apb_wr && (paddr == `DAG_OFF_STAT_ZERO))
        begin
            page_d = pwdata[`DAG_PAGE_MSB:`DAG_PAGE_LSB];
            sel_d = pwdata[`DAG_SEL_MSB:`DAG_SEL_LSB];
            prev_d = sel_q;
        end
        if (instr_valid && instr_page_load)
        begin
            page_d = instr_page_value;
        end
        if (instr_valid && instr_indirect && (instr_op != DAG_OP_NONE) && (instr_op < DAG_OP_CMP_EQ))
        begin
            pointer_regs_d[sel_q] = m.res;
        end
        if (instr_valid && instr_sel_load)
        begin
            sel_d = instr_sel_value;
            prev_d = sel_q;
        end
    end

    // Next state of the bus outputs and compare result
    always_comb
    begin
        rd_addr_d = rd_addr_q;
        wr_addr_d = wr_addr_q;
        rd_vld_d = 1'b0;
        wr_vld_d = 1'b0;
        last_wr_d = last_wr_q;
        cmp_d = cmp_q;
        if (instr_valid)
        begin
            last_wr_d = instr_write;
            if (instr_write)
            begin
                wr_addr_d = access_addr;
                wr_vld_d = 1'b1;
            end
            else
            begin
                rd_addr_d = access_addr;
                rd_vld_d = 1'b1;
            end
        end
        case (m.op)
            DAG_OP_CMP_EQ: cmp_d = m.eq;
            DAG_OP_CMP_LT: cmp_d = m.lt;
            DAG_OP_CMP_GT: cmp_d = !m.lt && !m.eq;
            default: cmp_d = cmp_q;
        endcase
    end

    // APB answer: ready in the first access cycle, read data caught at setup
    always_comb
    begin
        pready_d = apb_setup;
        pslverr_d = apb_setup && !is_mapped(paddr);
        prdata_d = apb_setup ? 32'h0000_0000 : prdata_q;
        if (apb_setup)
        begin
            if (is_ptr(paddr))
            begin
                prdata_d[15:0] = pointer_regs_q[ptr_idx(paddr)];
            end
            else if (paddr == `DAG_OFF_STAT_ZERO)
            begin
                prdata_d[`DAG_PAGE_MSB:`DAG_PAGE_LSB] = page_q;
                prdata_d[`DAG_SEL_MSB:`DAG_SEL_LSB] = sel_q;
            end
            else if (paddr == `DAG_OFF_STAT_ONE)
            begin
                prdata_d[`DAG_SEL_MSB:`DAG_SEL_LSB] = prev_q;
                prdata_d[`DAG_MAP_BIT] = map_q;
            end
            else if (paddr == `DAG_OFF_LAST)
            begin
                // Last address shows the block's own activity to software
                prdata_d[15:0] = last_wr_q ? wr_addr_q : rd_addr_q;
                prdata_d[`DAG_LAST_WR_BIT] = last_wr_q;
                prdata_d[`DAG_LAST_CMP_BIT] = cmp_q;
            end
        end
    end

    // Pointer register flops, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PTR; gi++)
        begin : g_ptr
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pointer_regs_q[gi] <= `DAG_RST_PTR;
                end
                else
                begin
                    pointer_regs_q[gi] <= pointer_regs_d[gi];
                end
            end
        end
    endgenerate

    // Status and output flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q <= `DAG_RST_SEL;
            prev_q <= `DAG_RST_SEL;
            page_q <= `DAG_RST_PAGE;
            map_q <= `DAG_RST_MAP;
            rd_addr_q <= 16'h0000;
            wr_addr_q <= 16'h0000;
            rd_vld_q <= 1'b0;
            wr_vld_q <= 1'b0;
            last_wr_q <= 1'b0;
            cmp_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            sel_q <= sel_d;
            prev_q <= prev_d;
            page_q <= page_d;
            map_q <= map_d;
            rd_addr_q <= rd_addr_d;
            wr_addr_q <= wr_addr_d;
            rd_vld_q <= rd_vld_d;
            wr_vld_q <= wr_vld_d;
            last_wr_q <= last_wr_d;
            cmp_q <= cmp_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Outputs straight from flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign read_addr_bus = rd_addr_q;
    assign read_valid = rd_vld_q;
    assign write_addr_bus = wr_addr_q;
    assign write_valid = wr_vld_q;
    assign cmp_true = cmp_q;
    assign block_zero_map_flag = map_q;
    assign current_pointer_select = sel_q;
endmodule
`default_nettype wire

// ===== sim/dag_top_chk_sva.sv
// Checker for the data address generator, on top-level ports only.
// Assumes one pclk domain with asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module dag_top_chk
(
    // Clock, reset, APB handshake
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Decoder request
    input wire logic instr_valid,
    input wire logic instr_indirect,
    input wire logic instr_write,
    input wire logic [6:0] instr_offset,
    input wire dag_pkg::dag_op_t instr_op,
    input wire logic instr_sel_load,
    input wire dag_pkg::dag_sel_t instr_sel_value,
    input wire logic instr_page_load,
    input wire dag_pkg::dag_page_t instr_page_value,
    // Address buses and selector
    input wire dag_pkg::dag_word_t read_addr_bus,
    input wire logic read_valid,
    input wire dag_pkg::dag_word_t write_addr_bus,
    input wire logic write_valid,
    input wire dag_pkg::dag_sel_t current_pointer_select
);
    import dag_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Each access lands on its own bus, one pulse only
    rd_pulse_a: assert property (instr_valid && !instr_write |=> read_valid && !write_valid)
        else $error("read access without a lone read pulse");
    wr_pulse_a: assert property (instr_valid && instr_write |=> write_valid && !read_valid)
        else $error("write access without a lone write pulse");
    idle_quiet_a: assert property (!instr_valid |=> !read_valid && !write_valid)
        else $error("address pulse without an access");
    // Direct addresses: offset below, page above
    dir_offset_a: assert property (instr_valid && !instr_indirect && !instr_write |=>
        read_addr_bus[6:0] == $past(instr_offset)) else $error("direct offset wrong");
    dir_page_a: assert property (instr_valid && instr_page_load ##1 instr_valid && !instr_indirect
        && instr_write && !instr_page_load |=> write_addr_bus[15:7] == $past(instr_page_value, 2))
        else $error("direct page wrong");
    // Selector load is visible after the loading access
    sel_load_a: assert property (instr_valid && instr_sel_load |=> current_pointer_select == $past(instr_sel_value))
        else $error("selector not loaded");
    // Increment shows on the next indirect read, wrapping silently
    inc_step_a: assert property (instr_valid && instr_indirect && !instr_write && !instr_sel_load
        && instr_op == DAG_OP_INC ##1 instr_valid && instr_indirect && !instr_write && !instr_sel_load
        |=> read_addr_bus == $past(read_addr_bus) + 16'h0001) else $error("increment step wrong");
    // APB answers in the first access cycle
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    cover property (instr_valid && instr_indirect && instr_sel_load);
    cover property (instr_valid && instr_page_load ##1 instr_valid && !instr_indirect);
    cover property (pready && pslverr);
endmodule
bind dag_top dag_top_chk chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .instr_valid,
    .instr_indirect, .instr_write, .instr_offset, .instr_op, .instr_sel_load, .instr_sel_value,
    .instr_page_load, .instr_page_value, .read_addr_bus, .read_valid, .write_addr_bus, .write_valid,
    .current_pointer_select);
`default_nettype wire

// ===== sim/dag_mem_model.sv
// Data memory side: records each address the generator drives.
// Assumes one-cycle valid pulses in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module dag_mem_model
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Address buses
    input wire logic read_valid,
    input wire logic write_valid,
    input wire dag_pkg::dag_word_t read_addr_bus,
    input wire dag_pkg::dag_word_t write_addr_bus,
    // Last access seen
    output logic seen,
    output logic seen_wr,
    output dag_pkg::dag_word_t seen_addr
);
    import dag_pkg::*;
    // One access a cycle; a double pulse reads as a write and misses the read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seen <= 1'h0;
            seen_wr <= 1'h0;
            seen_addr <= 16'h0000;
        end
        else
        begin
            seen <= read_valid | write_valid;
            seen_wr <= write_valid;
            seen_addr <= write_valid ? write_addr_bus : read_addr_bus;
        end
    end
endmodule
`default_nettype wire

// ===== sim/data_address_generator_tb.sv
// Testbench for the data address generator: APB traffic and decoder accesses.
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module data_address_generator_tb;
    import dag_pkg::*;
    localparam logic [32:0] NIL = 33'h0_0000_0000;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, instr_valid = 0, instr_indirect = 0;
    logic instr_write = 0, instr_sel_load = 0, instr_page_load = 0, pready, pslverr, read_valid, write_valid;
    logic cmp_true, block_zero_map_flag, seen, seen_wr, flag = 0, cmp = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [6:0] instr_offset = 0, off;
    dag_op_t instr_op = DAG_OP_NONE;
    dag_sel_t instr_sel_value = 0, current_pointer_select, sel = 0, prev = 0;
    dag_page_t instr_page_value = 0, page = 0, pg;
    dag_word_t read_addr_bus, write_addr_bus, seen_addr, ptr [8];
    logic [32:0] apb_q [$];
    logic [16:0] acc_q [$];
    logic [16:0] lst = 0;
    int err_total = 0, checked = 0, cyc = 0, seed = 55984, i;
    always #25 pclk = ~pclk;
    dag_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .instr_valid, .instr_indirect, .instr_write, .instr_offset, .instr_op, .instr_sel_load, .instr_sel_value,
        .instr_page_load, .instr_page_value, .read_addr_bus, .read_valid, .write_addr_bus, .write_valid, .cmp_true,
        .block_zero_map_flag, .current_pointer_select);
    dag_mem_model mem_u (.pclk, .presetn, .read_valid, .write_valid, .read_addr_bus, .write_addr_bus,
        .seen, .seen_wr, .seen_addr);
    function automatic dag_word_t rv(input dag_word_t x);
        for (int k = 0; k < 16; k++)
            rv[k] = x[15 - k];
    endfunction
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task complete_run;
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // APB transfer; the outcome is noted for the monitor
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        apb_q.push_back(e);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // Held until pready is seen high at a rising edge
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // Decoder access; valid stays up so accesses can run back to back
    task acc(input logic ind, wr, input logic [6:0] o, input dag_op_t op, input logic sl, input dag_sel_t sv,
        input logic dl, input dag_page_t dv);
        lst = {wr, ind ? ptr[sel] : {page, o}};
        acc_q.push_back(lst);
        instr_valid <= 1'h1;
        instr_indirect <= ind;
        instr_write <= wr;
        instr_offset <= o;
        instr_op <= op;
        instr_sel_load <= sl;
        instr_sel_value <= sv;
        instr_page_load <= dl;
        instr_page_value <= dv;
        cmp = (op == DAG_OP_CMP_EQ) ? ptr[sel] == ptr[0] : (op == DAG_OP_CMP_LT) ? ptr[sel] < ptr[0] :
            (op == DAG_OP_CMP_GT) ? ptr[sel] > ptr[0] : cmp;
        if (ind)
            case (op)
                DAG_OP_INC: ptr[sel] = ptr[sel] + 16'h0001;
                DAG_OP_DEC: ptr[sel] = ptr[sel] - 16'h0001;
                DAG_OP_BR_INC: ptr[sel] = rv(rv(ptr[sel]) + rv(ptr[0]));
                DAG_OP_BR_DEC: ptr[sel] = rv(rv(ptr[sel]) - rv(ptr[0]));
                default: ;
            endcase
        prev = sl ? sel : prev;
        sel = sl ? sv : sel;
        page = dl ? dv : page;
        @(posedge pclk);
    endtask
    task idle;
        instr_valid <= 1'h0;
        @(posedge pclk);
    endtask
    // Results as they appear, against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready)
            chk("apb", apb_q.pop_front(), {pslverr, pwrite ? 32'h0000_0000 : prdata});
        if (seen)
            chk("address", {16'h0000, acc_q.pop_front()}, {16'h0000, seen_wr, seen_addr});
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            complete_run;
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // Reset state of status words and pointers
        for (i = 0; i < 10; i++)
            apb(1'h0, (i < 2) ? 12'(4 * i) : 12'(4 * i + 24), 32'h0000_0000, NIL);
        // Random pointers; the last sits at the wrap edge
        for (i = 0; i < 8; i++)
        begin
            ptr[i] = (i == 7) ? 16'hFFFF : 16'($random(seed));
            apb(1'h1, 12'(4 * i + 32), {16'h0000, ptr[i]}, NIL);
            apb(1'h0, 12'(4 * i + 32), 32'h0000_0000, {17'h0_0000, ptr[i]});
        end
        apb(1'h1, 12'h004, 32'h0000_1000, NIL);
        flag = 1'h1;
        apb(1'h0, 12'h040, 32'h0000_0000, 33'h1_0000_0000);
        chk("map_flag", {32'h0000_0000, flag}, {32'h0000_0000, block_zero_map_flag});
        // Selector walk; each access still uses the old selector
        for (i = 0; i < 8; i++)
            acc(1'h1, 1'h0, 7'h00, DAG_OP_NONE, 1'h1, 3'(i), 1'h0, 9'h000);
        idle();
        chk("select", {30'h0000_0000, sel}, {30'h0000_0000, current_pointer_select});
        apb(1'h0, 12'h004, 32'h0000_0000, {17'h0_0000, prev, flag, 12'h000});
        apb(1'h0, 12'h000, 32'h0000_0000, {17'h0_0000, sel, 4'h0, page});
        // Every pointer operation, then a plain access showing the result
        for (i = 1; i < 8; i++)
        begin
            acc(1'h1, 1'h0, 7'h00, dag_op_t'(i), 1'h0, sel, 1'h0, 9'h000);
            acc(1'h1, 1'h0, 7'h00, DAG_OP_NONE, 1'h0, sel, 1'h0, 9'h000);
            idle();
            chk("compare", {32'h0000_0000, cmp}, {32'h0000_0000, cmp_true});
        end
        // Direct accesses on first, last and a random page
        for (i = 0; i < 3; i++)
        begin
            pg = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
            off = (i == 1) ? 7'h7F : 7'($random(seed));
            acc(1'h0, 1'h0, off, DAG_OP_NONE, 1'h0, sel, 1'h1, pg);
            acc(1'h0, 1'h1, off, DAG_OP_NONE, 1'h0, sel, 1'h0, 9'h000);
            idle();
        end
        // Last-access word: address, write flag and compare result
        apb(1'h0, 12'h008, 32'h0000_0000, {15'h0000, cmp, lst});
        repeat (4) @(posedge pclk);
        chk("drained", 33'(acc_q.size() + apb_q.size()), NIL);
        complete_run;
    end
endmodule
`default_nettype wire
